// File: rtl/wpt_cfg.svh
// Purpose: Constants for the I2C wiper potentiometer target
// Assumes: Single 20 MHz system clock samples the I2C pins
// Notes: Definitions only
`ifndef WPT_CFG_SVH
`define WPT_CFG_SVH

// ==========================================
// Addressing, reset values, widths and bit positions
`define WPT_SLAVE_ADDR 7'h2F
`define WPT_GCALL_ADDR 7'h00
`define WPT_WIPER_RESET 7'h3F
`define WPT_WIPER_W 7
`define WPT_TAP_COUNT 128
`define WPT_RW_BIT 0
`define WPT_LAST_BIT 3'h7

`endif

// File: rtl/wpt_pkg.sv
// Purpose: Types for the I2C wiper potentiometer target
// Assumes: Included constants come from wpt_cfg.svh
// Notes: Types only
package wpt_pkg;
  // ==========================================
  // Bus interface states, one-hot
  typedef enum logic [4:0] {
    WPT_IDLE  = 5'b00001,
    WPT_ADDR  = 5'b00010,
    WPT_WDATA = 5'b00100,
    WPT_RDATA = 5'b01000,
    WPT_ACK   = 5'b10000
  } wpt_state_t;

  // Two-entry buffer state
  typedef struct packed {
    logic [1:0] cnt;
    logic rd_ptr;
    logic wr_ptr;
  } wpt_buf_t;
endpackage

// File: rtl/wpt_buf2.sv
// Purpose: Two-entry valid/ready buffer for received wiper codes
// Assumes: Same clock on both sides
// Notes: Ready drops only when both entries hold data
`include "wpt_cfg.svh"
module wpt_buf2 (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [`WPT_WIPER_W-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [`WPT_WIPER_W-1:0] out_data_o
);
  logic [`WPT_WIPER_W-1:0] mem [0:1];
  wpt_pkg::wpt_buf_t st;
  wpt_pkg::wpt_buf_t next_st;
  logic push;
  logic pop;

  assign in_ready_o = (st.cnt != 2'h2);
  assign out_valid_o = (st.cnt != 2'h0);
  assign out_data_o = mem[st.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = ~st.wr_ptr;
    end
    if (pop) begin
      next_st.rd_ptr = ~st.rd_ptr;
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[st.wr_ptr] <= in_data_i;
    end
  end
endmodule

// File: rtl/wpt_i2c_target.sv
// Purpose: I2C target holding a 7-bit volatile wiper code and tap select
// Assumes: SCL and SDA pins are oversampled by clock_i, two-stage synchronised
// Notes: rstn_i stands for power-on and brown-out reset
`include "wpt_cfg.svh"

module wpt_i2c_target (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // I2C pins, open drain, oe low means driving low
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic scl_o,
  output logic scl_oe_o,
  // Wiper outputs
  output logic [`WPT_WIPER_W-1:0] volatile_wiper_setting_o,
  output logic [`WPT_TAP_COUNT-1:0] tap_select_o
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    wpt_pkg::wpt_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic is_read;
    logic ack_drive;
    logic sda_low;
    logic got_byte;
    logic sda_rel;
    logic [`WPT_WIPER_W-1:0] wiper;
    logic [`WPT_TAP_COUNT-1:0] taps;
  } wpt_core_t;

  wpt_core_t st;
  wpt_core_t next_st;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [`WPT_WIPER_W-1:0] buf_out_data;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // ==========================================
  // Tap decode
  function automatic logic [`WPT_TAP_COUNT-1:0] tap_decode(
    input logic [`WPT_WIPER_W-1:0] code
  );
    logic [`WPT_TAP_COUNT-1:0] v;
    v = '0;
    v[code] = 1'b1;
    return v;
  endfunction

  assign scl_rise = st.scl_s[1] && !st.scl_d;
  assign scl_fall = !st.scl_s[1] && st.scl_d;
  assign start_seen = st.scl_s[1] && st.scl_d && st.sda_d && !st.sda_s[1];
  assign stop_seen = st.scl_s[1] && st.scl_d && !st.sda_d && st.sda_s[1];

  // ==========================================
  // Receive buffer toward the wiper register
  wpt_buf2 u_buf (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .in_valid_i(buf_in_valid),
    .in_data_i(st.shreg[`WPT_WIPER_W-1:0]),
    .in_ready_o(buf_in_ready),
    .out_valid_o(buf_out_valid),
    .out_ready_i(1'b1),
    .out_data_o(buf_out_data)
  );

  // ==========================================
  // Protocol engine
  always_comb begin
    next_st = st;
    buf_in_valid = 1'b0;
    next_st.scl_s = {st.scl_s[0], scl_i};
    next_st.sda_s = {st.sda_s[0], sda_i};
    next_st.scl_d = st.scl_s[1];
    next_st.sda_d = st.sda_s[1];
    if (buf_out_valid) begin
      next_st.wiper = buf_out_data;
    end
    next_st.taps = tap_decode(next_st.wiper);
    if (stop_seen) begin
      next_st.state = wpt_pkg::WPT_IDLE;
      next_st.sda_low = 1'b0;
    end else if (start_seen) begin
      next_st.state = wpt_pkg::WPT_ADDR;
      next_st.bit_cnt = 3'h0;
      next_st.got_byte = 1'b0;
      next_st.sda_low = 1'b0;
    end else begin
      case (st.state)
        wpt_pkg::WPT_IDLE: begin
          next_st.sda_low = 1'b0;
        end
        wpt_pkg::WPT_ADDR, wpt_pkg::WPT_WDATA: begin
          if (scl_rise) begin
            next_st.shreg = {st.shreg[6:0], st.sda_s[1]};
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            // Marks a full byte, so the fall that ends a start is not taken
            next_st.got_byte = (st.bit_cnt == `WPT_LAST_BIT);
          end
          if (scl_fall && st.got_byte) begin
            // Eight bits in; decide acknowledge on the falling edge
            next_st.state = wpt_pkg::WPT_ACK;
            next_st.got_byte = 1'b0;
            if (st.state == wpt_pkg::WPT_ADDR) begin
              next_st.is_read = st.shreg[`WPT_RW_BIT];
              if (st.shreg[7:1] == `WPT_SLAVE_ADDR) begin
                next_st.sda_low = 1'b1;
                next_st.ack_drive = 1'b1;
              end else begin
                next_st.state = wpt_pkg::WPT_IDLE;
              end
            end else begin
              next_st.is_read = 1'b0;
              next_st.ack_drive = 1'b1;
              next_st.sda_low = buf_in_ready;
              buf_in_valid = buf_in_ready;
            end
          end
        end
        wpt_pkg::WPT_ACK: begin
          if (scl_fall) begin
            next_st.ack_drive = 1'b0;
            next_st.bit_cnt = 3'h0;
            if (st.is_read) begin
              // Load wiper code and drive first bit
              next_st.shreg = {1'b0, st.wiper};
              next_st.sda_low = 1'b1;
              next_st.state = wpt_pkg::WPT_RDATA;
            end else begin
              next_st.sda_low = 1'b0;
              next_st.state = wpt_pkg::WPT_WDATA;
            end
          end else if (scl_rise && !st.ack_drive && st.sda_s[1]) begin
            next_st.state = wpt_pkg::WPT_IDLE;
          end
        end
        wpt_pkg::WPT_RDATA: begin
          if (scl_fall) begin
            if (st.bit_cnt == `WPT_LAST_BIT) begin
              next_st.sda_low = 1'b0;
              next_st.state = wpt_pkg::WPT_ACK;
              next_st.ack_drive = 1'b0;
              next_st.is_read = 1'b1;
            end else begin
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.bit_cnt = st.bit_cnt + 3'h1;
              next_st.sda_low = !st.shreg[6];
            end
          end
        end
        default: begin
          next_st.state = wpt_pkg::WPT_IDLE;
        end
      endcase
    end
    // Drive low while shifting the MSB of read byte
    if (next_st.state == wpt_pkg::WPT_RDATA && scl_fall && !stop_seen && !start_seen
        && st.state == wpt_pkg::WPT_ACK) begin
      next_st.sda_low = 1'b1; // MSB of returned byte is always zero
    end
    // Pin enable held in a flop of its own, active low
    next_st.sda_rel = !next_st.sda_low;
  end

  // ==========================================
  // State register
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
      st.scl_s <= 2'h3;
      st.sda_s <= 2'h3;
      st.scl_d <= 1'b1;
      st.sda_d <= 1'b1;
      st.sda_rel <= 1'b1;
      st.state <= wpt_pkg::WPT_IDLE;
      st.wiper <= `WPT_WIPER_RESET;
      st.taps <= 128'h0000_0000_0000_0000_8000_0000_0000_0000;
    end else begin
      st <= next_st;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = st.sda_rel;
  assign scl_o = 1'b0;
  assign scl_oe_o = 1'b1;
  assign volatile_wiper_setting_o = st.wiper;
  assign tap_select_o = st.taps;
endmodule

// File: sim/wpt_i2c_target_chk.sv
// Purpose: Assertions on the wiper target pins
// Assumes: Master keeps SCL phases of at least 6 clocks
// Notes: Bound to wpt_i2c_target
`include "wpt_cfg.svh"
module wpt_i2c_target_chk (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Pins and wiper
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_o,
  input wire logic scl_oe_o,
  input wire logic [`WPT_WIPER_W-1:0] volatile_wiper_setting_o,
  input wire logic [`WPT_TAP_COUNT-1:0] tap_select_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Bus conditions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence start_s;
    scl_i && $fell(sda_i);
  endsequence
  sequence stop_s;
    scl_i && $rose(sda_i);
  endsequence
  // ==========================================
  // Checks
  scl_free_a: assert property (scl_oe_o) else $error("scl driven");
  tap_decode_a: assert property (tap_select_o == (`WPT_TAP_COUNT'(1) << volatile_wiper_setting_o))
    else $error("tap not one-hot of wiper");
  wiper_at_ack_a: assert property ($changed(volatile_wiper_setting_o) |-> !sda_oe_o)
    else $error("wiper changed outside ack");
  sda_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("sda moved in scl high");
  ack_hold_a: assert property ($fell(sda_oe_o) |-> !sda_oe_o[*6])
    else $error("sda drive too short");
  start_idle_a: assert property (start_s |-> ##1 sda_oe_o[*8])
    else $error("drive after start");
  stop_idle_a: assert property (stop_s |-> ##1 sda_oe_o[*8])
    else $error("drive after stop");
  stop_keep_a: assert property (stop_s |-> ##1 $stable(volatile_wiper_setting_o)[*8])
    else $error("wiper changed after stop");
endmodule

bind wpt_i2c_target wpt_i2c_target_chk wpt_chk_inst (.clock_i(clock_i), .rstn_i(rstn_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o), .scl_oe_o(scl_oe_o),
  .volatile_wiper_setting_o(volatile_wiper_setting_o), .tap_select_o(tap_select_o));

// File: sim/wpt_master.sv
// Purpose: I2C bus master model
// Assumes: SCL low 10 and high 8 clocks
// Notes: Tasks called by the bench
module wpt_master (
  // Clock
  input wire logic clock_i,
  // Bus
  input wire logic sda_i,
  output logic scl_o = 1'b1,
  output logic sda_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Conditions and bits
  task automatic hold(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic start();
    sda_o <= 1'b1;
    hold(4);
    scl_o <= 1'b1;
    hold(8);
    sda_o <= 1'b0;
    hold(8);
    scl_o <= 1'b0;
    hold(2);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    hold(4);
    scl_o <= 1'b1;
    hold(8);
    sda_o <= 1'b1;
    hold(8);
  endtask
  task automatic xfer(input logic b, output logic r);
    sda_o <= b;
    hold(8);
    scl_o <= 1'b1;
    hold(4);
    r = sda_i;
    hold(4);
    scl_o <= 1'b0;
    hold(2);
  endtask
  task automatic send(input logic [7:0] d, input logic ack, output logic [7:0] r,
    output logic a);
    for (int i = 7; i >= 0; i--) xfer(d[i], r[i]);
    xfer(ack, a);
  endtask
endmodule

// File: sim/i2c_wiper_pot_slave_bench.sv
// Purpose: Self-checking bench for the I2C wiper target
// Assumes: Master model paces the bus
// Notes: Wiper updates scoreboarded via a queue
module i2c_wiper_pot_slave_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic scl_m, sda_m, sda_t, sda_oe, scl_t, scl_oe, a;
  logic [7:0] r;
  logic [6:0] wiper, mw, last_w;
  logic [127:0] tap;
  logic [6:0] exp_q[$];
  logic [7:0] bad[4] = '{8'h00, 8'h5C, 8'hDE, 8'h1F};
  int failures = 0;
  int n_checks = 0;
  wire scl_bus = scl_m & (scl_oe | scl_t);
  wire sda_bus = sda_m & (sda_oe | sda_t);
  always #25 clock = ~clock;
  wpt_master wpt_master_inst (.clock_i(clock), .sda_i(sda_bus), .scl_o(scl_m), .sda_o(sda_m));
  wpt_i2c_target wpt_i2c_target_inst (.clock_i(clock), .rstn_i(rstn), .scl_i(scl_bus),
    .sda_i(sda_bus), .sda_o(sda_t), .sda_oe_o(sda_oe), .scl_o(scl_t), .scl_oe_o(scl_oe),
    .volatile_wiper_setting_o(wiper), .tap_select_o(tap));
  // ==========================================
  // Helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tx(input logic [7:0] d, input logic ack);
    wpt_master_inst.send(d, ack, r, a);
  endtask
  task automatic addr(input logic [7:0] ad, input logic e);
    wpt_master_inst.start();
    tx(ad, 1'b1);
    check("addr ack", {7'b0, a}, {7'b0, e});
  endtask
  task automatic wr(input logic [7:0] d);
    // Note first: the wiper moves before the byte's ack slot ends
    if (d[6:0] != mw) exp_q.push_back(d[6:0]);
    mw = d[6:0];
    tx(d, 1'b1);
    check("data ack", {7'b0, a}, 8'h00);
  endtask
  task automatic rd(input logic ack);
    tx(8'hFF, ack);
    check("read", r, {1'b0, mw});
  endtask
  task automatic done(input string name);
    check("pending", 8'(exp_q.size()), 8'h00);
    $display("test %s done", name);
  endtask
  // ==========================================
  // Wiper monitor
  // Sampled on the falling clock edge, away from the rising edge that launches the wiper
  always @(negedge clock) begin
    if (!rstn) last_w <= 7'h3F;
    else if (wiper !== last_w) begin
      last_w <= wiper;
      check("wiper", {1'b0, wiper}, exp_q.size() ? {1'b0, exp_q.pop_front()} : 8'hFF);
    end
  end
  initial begin
    #3000000;
    failures++;
    finish_test();
  end
  initial begin
    void'($urandom(32));
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    mw = 7'h3F;
    repeat (3) @(posedge clock);
    check("reset wiper", {1'b0, wiper}, 8'h3F);
    check("reset tap", {7'b0, tap[63]}, 8'h01);
    done("reset");
    addr(8'h5E, 1'b0);
    wr(8'h80 | 8'($urandom));
    wr(8'($urandom));
    wr(8'hFF);
    addr(8'h5F, 1'b0);
    rd(1'b0);
    rd(1'b1);
    wpt_master_inst.stop();
    done("write read");
    foreach (bad[i]) begin
      addr(bad[i], 1'b1);
      tx(8'h06, 1'b1);
      check("ignored", {7'b0, a}, 8'h01);
      wpt_master_inst.stop();
    end
    done("bad address");
    addr(8'h5E, 1'b0);
    repeat (4) wpt_master_inst.xfer(1'b1, a);
    addr(8'h5E, 1'b0);
    wr(8'h00);
    repeat (4) wpt_master_inst.xfer(1'b1, a);
    wpt_master_inst.stop();
    done("partial byte");
    addr(8'h5F, 1'b0);
    repeat (3) wpt_master_inst.xfer(1'b1, a);
    wpt_master_inst.start();
    repeat (9) wpt_master_inst.xfer(1'b1, a);
    wpt_master_inst.start();
    wpt_master_inst.stop();
    addr(8'h5F, 1'b0);
    rd(1'b1);
    wpt_master_inst.stop();
    done("soft reset");
    finish_test();
  end
endmodule
